// ===== verilog/codec_power_clock_control_regs.sv
`timescale 1ns/1ns
// Contract
// - Each power-enable bit keeps its function up when 1 and down when 0, all 0 after reset.
// - Bits 15..0: multiplier, reference, ADC, line DACs 4..1, aux pairs, amp pair, SRC, engine, core.
// - Headphone level bit 7 mutes and bits 4..0 attenuate in 1.5 dB steps.
// - Clock setup bits 12..9 always read as ones, giving 0x1E00 after reset while the lock flag is low.
// - Clock setup bit 8 enables the rate-converter mux and bit 7 reads the live lock flag.
// - Clock setup bit 6 enables the master-clock output pin.
// - Clock setup bits 5..3 pick 1024x for 001 and 128x for 1xx; other codes are reserved.
// - Clock setup bits 2..1 pick a 64/128/256/512x input ratio and bit 0 uses the multiplier.
// - Chop setup bit 4 turns amplifier chopping on when 0 and off when 1.
module codec_power_clock_control_regs
	import codec_ctrl_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic [codec_ctrl_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [codec_ctrl_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic src_locked_in,
	output logic [codec_ctrl_pkg::DATA_W-1:0] reg_rdata_out,
	output logic reg_hit_out,
	output logic pll_pwr_out,
	output logic refbuf_pwr_out,
	output logic adc_pwr_out,
	output logic [3:0] line_output_dac_pwr_out,
	output logic [1:0] second_auxiliary_output_dac_pwr_out,
	output logic [1:0] first_auxiliary_headphone_output_dac_pwr_out,
	output logic [1:0] hp_amp_pwr_out,
	output logic src_pwr_out,
	output logic conv_engine_pwr_out,
	output logic audio_proc_pwr_out,
	output logic hp_mute_out,
	output logic [4:0] hp_atten_out,
	output logic src_mux_en_out,
	output logic master_clock_out_pin_en_out,
	output logic [1:0] master_clock_out_pin_rate_out,
	output logic [1:0] pll_ratio_out,
	output logic pll_use_out,
	output logic dac_amp_chop_en_out
);
	import codec_ctrl_pkg::*;

	logic [15:0] pwr_q;
	logic [15:0] clkset_q;
	logic [15:0] hplvl_q;
	logic [15:0] chop_q;

	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic [15:0] clkset_view;
	logic [15:0] pwr_rd;
	logic [15:0] clk_rd;
	logic [15:0] hp_rd;
	logic [15:0] chop_rd;

	logic [3:0] sel_vec;
	logic [2:0] mclk_sel;
	logic mclk_is_128;
	logic mclk_is_1024;

	logic sel_pwr;
	logic sel_clk;
	logic sel_hp;
	logic sel_chop;
	logic wr_pwr;
	logic wr_clk;
	logic wr_hp;
	logic wr_chop;

	////////////////////////////////////////////////////////////////
	// Full 16-bit compares, so aliases of a register address never hit.
	assign sel_pwr = reg_addr_in == PWR_ADDR;
	assign sel_clk = reg_addr_in == CLKSET_ADDR;
	assign sel_hp = reg_addr_in == HPLVL_ADDR;
	assign sel_chop = reg_addr_in == CHOP_ADDR;
	assign sel_vec = {sel_chop, sel_hp, sel_clk, sel_pwr};

	// Unmapped writes raise no enable, so they change nothing.
	assign wr_pwr = reg_wr_in & sel_pwr;
	assign wr_clk = reg_wr_in & sel_clk;
	assign wr_hp = reg_wr_in & sel_hp;
	assign wr_chop = reg_wr_in & sel_chop;

	////////////////////////////////////////////////////////////////
	// Only writable bits are stored so reserved bits cannot leak back.
	masked_field_reg #(
		.RESET_VAL(PWR_RESET),
		.WRITE_MASK(PWR_WMASK)
	) pwr_reg (
		.clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.wr_en_in(wr_pwr),
		.wdata_in(reg_wdata_in),
		.q_out(pwr_q)
	);

	// The ones field and the lock flag are not stored; the read path makes them.
	masked_field_reg #(
		.RESET_VAL(CLKSET_RESET),
		.WRITE_MASK(CLKSET_WMASK)
	) clkset_reg (
		.clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.wr_en_in(wr_clk),
		.wdata_in(reg_wdata_in),
		.q_out(clkset_q)
	);

	masked_field_reg #(
		.RESET_VAL(HPLVL_RESET),
		.WRITE_MASK(HPLVL_WMASK)
	) hplvl_reg (
		.clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.wr_en_in(wr_hp),
		.wdata_in(reg_wdata_in),
		.q_out(hplvl_q)
	);

	masked_field_reg #(
		.RESET_VAL(CHOP_RESET),
		.WRITE_MASK(CHOP_WMASK)
	) chop_reg (
		.clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.wr_en_in(wr_chop),
		.wdata_in(reg_wdata_in),
		.q_out(chop_q)
	);

	////////////////////////////////////////////////////////////////
	// The lock flag is sampled live at read time, it is not stored.
	always_comb begin
		clkset_view = clkset_q | CLKSET_ONES;
		clkset_view[CLKSET_LOCK_BIT] = src_locked_in;
	end

	////////////////////////////////////////////////////////////////
	// AND-OR selection: an unmapped address selects nothing and reads zero.
	assign pwr_rd = sel_pwr ? pwr_q : 16'h0000;
	assign clk_rd = sel_clk ? clkset_view : 16'h0000;
	assign hp_rd = sel_hp ? hplvl_q : 16'h0000;
	assign chop_rd = sel_chop ? chop_q : 16'h0000;
	assign rdata_d = pwr_rd | clk_rd | hp_rd | chop_rd;

	// Read data holds between reads, so a slow reader may take it late.
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd_in) begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign reg_hit_out = |sel_vec;

	////////////////////////////////////////////////////////////////
	// Every function starts powered down, since the word resets to zero.
	assign pll_pwr_out = pwr_q[15];
	assign refbuf_pwr_out = pwr_q[14];
	assign adc_pwr_out = pwr_q[13];
	assign line_output_dac_pwr_out = pwr_q[12:9];
	assign second_auxiliary_output_dac_pwr_out = pwr_q[8:7];
	assign first_auxiliary_headphone_output_dac_pwr_out = pwr_q[6:5];
	assign hp_amp_pwr_out = pwr_q[4:3];
	assign src_pwr_out = pwr_q[2];
	assign conv_engine_pwr_out = pwr_q[1];
	assign audio_proc_pwr_out = pwr_q[0];

	////////////////////////////////////////////////////////////////
	// Mute and attenuation are plain register bits; the amplifier combines them.
	assign hp_mute_out = hplvl_q[HPLVL_MUTE_BIT];
	assign hp_atten_out = hplvl_q[HPLVL_ATTEN_LSB +: 5];

	////////////////////////////////////////////////////////////////
	assign src_mux_en_out = clkset_q[CLKSET_MUX_BIT];
	assign master_clock_out_pin_en_out = clkset_q[CLKSET_MCLK_EN_BIT];
	assign mclk_sel = clkset_q[CLKSET_MCLK_SEL_LSB +: 3];
	assign mclk_is_128 = mclk_sel[2];
	assign mclk_is_1024 = mclk_sel == MCLK_SEL_1024;
	// Reserved rate codes yield no rate rather than guessing one.
	assign master_clock_out_pin_rate_out = mclk_is_128 ? MCLK_RATE_128 :
		mclk_is_1024 ? MCLK_RATE_1024 : MCLK_RATE_NONE;
	// Ratio and bypass take effect one cycle after the write.
	assign pll_ratio_out = clkset_q[CLKSET_PLL_SEL_LSB +: 2];
	assign pll_use_out = clkset_q[CLKSET_PLL_EN_BIT];

	////////////////////////////////////////////////////////////////
	// Chopping is on after reset; software should turn it off for best performance.
	assign dac_amp_chop_en_out = ~chop_q[CHOP_OFF_BIT];
endmodule

////////////////////////////////////////////////////////////////
// One stored word; bits outside the mask always hold zero, whatever is written.
module masked_field_reg #(
	parameter logic [15:0] RESET_VAL = 16'h0000,
	parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic wr_en_in,
	input wire logic [15:0] wdata_in,
	output logic [15:0] q_out
);

	logic [15:0] masked_wdata;

	assign masked_wdata = wdata_in & WRITE_MASK;

	// The reset value is masked too, so a wrong default cannot set a reserved bit.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q_out <= RESET_VAL & WRITE_MASK;
		end else if (wr_en_in) begin
			q_out <= masked_wdata;
		end
	end
endmodule

// ===== verilog/codec_ctrl_pkg.sv
package codec_ctrl_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam logic [15:0] PWR_ADDR = 16'h1058;
	localparam logic [15:0] CLKSET_ADDR = 16'h1059;
	localparam logic [15:0] HPLVL_ADDR = 16'h105A;
	localparam logic [15:0] CHOP_ADDR = 16'h110D;
	localparam logic [15:0] PWR_RESET = 16'h0000;
	localparam logic [15:0] CLKSET_RESET = 16'h1E00;
	localparam logic [15:0] HPLVL_RESET = 16'h0000;
	localparam logic [15:0] CHOP_RESET = 16'h0000;
	// Writable bit masks; reserved bits are dropped on write.
	localparam logic [15:0] PWR_WMASK = 16'hFFFF;
	localparam logic [15:0] CLKSET_WMASK = 16'h017F;
	localparam logic [15:0] HPLVL_WMASK = 16'h009F;
	localparam logic [15:0] CHOP_WMASK = 16'h0010;
	localparam logic [15:0] CLKSET_ONES = 16'h1E00;
	localparam int CLKSET_LOCK_BIT = 7;
	localparam int CLKSET_MUX_BIT = 8;
	localparam int CLKSET_MCLK_EN_BIT = 6;
	localparam int CLKSET_MCLK_SEL_LSB = 3;
	localparam int CLKSET_PLL_SEL_LSB = 1;
	localparam int CLKSET_PLL_EN_BIT = 0;
	localparam int HPLVL_MUTE_BIT = 7;
	localparam int HPLVL_ATTEN_LSB = 0;
	localparam int CHOP_OFF_BIT = 4;
	localparam logic [2:0] MCLK_SEL_1024 = 3'h1;
	localparam logic [1:0] MCLK_RATE_NONE = 2'h0;
	localparam logic [1:0] MCLK_RATE_1024 = 2'h1;
	localparam logic [1:0] MCLK_RATE_128 = 2'h2;
endpackage

// ===== dv/codec_regs_props.sv
`timescale 1ns/1ns
module codec_regs_props
	import codec_ctrl_pkg::*;
(
	input logic ref_clk_in, arst_n_in, reg_wr_in, reg_rd_in, src_locked_in,
	input logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
	input logic pll_pwr_out, refbuf_pwr_out, adc_pwr_out, src_pwr_out, conv_engine_pwr_out,
	input logic audio_proc_pwr_out, hp_mute_out, src_mux_en_out, master_clock_out_pin_en_out,
	input logic pll_use_out, dac_amp_chop_en_out,
	input logic [3:0] line_output_dac_pwr_out,
	input logic [4:0] hp_atten_out,
	input logic [1:0] hp_amp_pwr_out, pll_ratio_out, master_clock_out_pin_rate_out,
	input logic [1:0] second_auxiliary_output_dac_pwr_out,
	input logic [1:0] first_auxiliary_headphone_output_dac_pwr_out
);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!arst_n_in);
wire w_clk = reg_wr_in && reg_addr_in == CLKSET_ADDR;
wire r_clk = reg_rd_in && reg_addr_in == CLKSET_ADDR;
wire [15:0] pwr = {pll_pwr_out, refbuf_pwr_out, adc_pwr_out, line_output_dac_pwr_out,
	second_auxiliary_output_dac_pwr_out, first_auxiliary_headphone_output_dac_pwr_out,
	hp_amp_pwr_out, src_pwr_out, conv_engine_pwr_out, audio_proc_pwr_out};
// Reserved codes must not produce a rate, so they decode to zero.
wire [1:0] rate_d = reg_wdata_in[5] ? 2'h2 : {1'b0, reg_wdata_in[5:3] == 3'h1};
////////////////////////////////////////////////////////////////////////////////
a_power_map: assert property (reg_wr_in && reg_addr_in == PWR_ADDR |=>
	pwr == $past(reg_wdata_in))
	else $error("power enables wrong");
a_hp_level: assert property (reg_wr_in && reg_addr_in == HPLVL_ADDR |=>
	{hp_mute_out, hp_atten_out} == {$past(reg_wdata_in[7]), $past(reg_wdata_in[4:0])})
	else $error("headphone level wrong");
a_ones_field: assert property (r_clk |=> reg_rdata_out[15:9] == 7'h0F)
	else $error("ones field wrong");
a_lock_read: assert property (r_clk |=> reg_rdata_out[7] == $past(src_locked_in))
	else $error("lock flag wrong");
a_mux_pin_en: assert property (w_clk |=>
	{src_mux_en_out, master_clock_out_pin_en_out} ==
	{$past(reg_wdata_in[8]), $past(reg_wdata_in[6])})
	else $error("mux or pin enable wrong");
a_mclk_rate: assert property (w_clk |=> master_clock_out_pin_rate_out == $past(rate_d))
	else $error("clock rate wrong");
a_pll_select: assert property (w_clk |=>
	{pll_ratio_out, pll_use_out} == $past(reg_wdata_in[2:0]))
	else $error("multiplier select wrong");
a_chop_ctrl: assert property (reg_wr_in && reg_addr_in == CHOP_ADDR |=>
	dac_amp_chop_en_out == !$past(reg_wdata_in[4]))
	else $error("chop control wrong");
c_clk_wr_rd: cover property (w_clk ##1 r_clk);
c_lock_seen: cover property (r_clk && src_locked_in);
c_pwr_wr: cover property (reg_wr_in && reg_addr_in == PWR_ADDR);
endmodule
bind codec_power_clock_control_regs codec_regs_props u_props (.*);

// ===== dv/codec_power_clock_control_regs_tb.sv
`timescale 1ns/1ns
module codec_power_clock_control_regs_tb;
import codec_ctrl_pkg::*;
logic clk = 0, arst_n = 0, wr = 0, rd = 0, lk = 0;
logic [15:0] a = 0, d = 0, wd;
logic [2:0] m;
wire [15:0] p, q;
wire [6:0] cs;
wire [5:0] hl;
wire hit, chop;
int error_cnt = 0, n_tests = 0;
always #20 clk = ~clk;
codec_power_clock_control_regs DUT (.ref_clk_in(clk), .arst_n_in(arst_n), .reg_addr_in(a),
	.reg_wdata_in(d), .reg_wr_in(wr), .reg_rd_in(rd), .src_locked_in(lk), .reg_rdata_out(q),
	.reg_hit_out(hit), .pll_pwr_out(p[15]), .refbuf_pwr_out(p[14]), .adc_pwr_out(p[13]),
	.line_output_dac_pwr_out(p[12:9]), .second_auxiliary_output_dac_pwr_out(p[8:7]),
	.first_auxiliary_headphone_output_dac_pwr_out(p[6:5]), .hp_amp_pwr_out(p[4:3]),
	.src_pwr_out(p[2]), .conv_engine_pwr_out(p[1]), .audio_proc_pwr_out(p[0]),
	.hp_mute_out(hl[5]), .hp_atten_out(hl[4:0]), .src_mux_en_out(cs[6]),
	.master_clock_out_pin_en_out(cs[5]), .master_clock_out_pin_rate_out(cs[4:3]),
	.pll_ratio_out(cs[2:1]), .pll_use_out(cs[0]), .dac_amp_chop_en_out(chop));
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
	n_tests++;
	if (got !== exp) begin
		error_cnt++;
		$display("Error at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task automatic wreg(input logic [15:0] ad, input logic [15:0] dt);
	@(negedge clk) a = ad; d = dt; wr = 1;
	@(negedge clk) wr = 0;
endtask
task automatic rreg(input logic [15:0] ad, input logic [15:0] ex);
	@(negedge clk) a = ad; rd = 1;
	@(negedge clk) rd = 0;
	chk(q, ex);
endtask
task automatic complete_run;
	$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
	if (error_cnt == 0 && n_tests > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	repeat (10) @(negedge clk);
	arst_n = 1;
	rreg(PWR_ADDR, 16'h0000);
	rreg(CLKSET_ADDR, 16'h1E00);
	rreg(HPLVL_ADDR, 16'h0000);
	rreg(CHOP_ADDR, 16'h0000);
	$display("Reset test done");
	wreg(PWR_ADDR, 16'hA5C3); chk(p, 16'hA5C3);
	wreg(PWR_ADDR, 16'h5A3C); chk(p, 16'h5A3C);
	wreg(HPLVL_ADDR, 16'hFFFF); chk({10'h0, hl}, 16'h003F);
	rreg(HPLVL_ADDR, 16'h009F);
	wreg(CHOP_ADDR, 16'hFFFF); chk({15'h0, chop}, 16'h0000);
	rreg(CHOP_ADDR, 16'h0010);
	wreg(CHOP_ADDR, 16'h0000); chk({15'h0, chop}, 16'h0001);
	$display("Power and level test done");
	for (int i = 0; i < 8; i++) begin
		lk = i[0];
		m = (i < 4) ? 3'h1 : 3'(i);
		wd = {7'h0, i[1], 1'b0, i[2], m, 2'(i), i[0]};
		wreg(CLKSET_ADDR, wd | 16'hE080);
		chk({9'h0, cs}, {9'h0, i[1], i[2], (i > 3) ? 2'h2 : 2'h1, 2'(i), i[0]});
		rreg(CLKSET_ADDR, wd | 16'h1E00 | {8'h0, lk, 7'h0});
	end
	$display("Clock setup test done");
	wreg(16'h105B, 16'hFFFF);
	rreg(16'h105B, 16'h0000); chk({15'h0, hit}, 16'h0000);
	rreg(PWR_ADDR, 16'h5A3C);
	chk({15'h0, hit}, 16'h0001);
	$display("Unmapped test done");
	complete_run();
end
initial begin
	#100000;
	error_cnt++;
	complete_run();
end
endmodule
